// file: logic/lmdc_pkg.sv
// Package with register map, reset values, field positions and types of the LAN MAC DMA control block.
package lmdc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] ADDR_RX_RESTART = 16'h800C;
  localparam logic [15:0] ADDR_TX_BASE    = 16'h8010;
  localparam logic [15:0] ADDR_RX_BASE    = 16'h8014;
  localparam logic [15:0] ADDR_SA_LOW     = 16'h8018;
  localparam logic [15:0] ADDR_SA_HIGH    = 16'h801C;
  localparam logic [15:0] ADDR_MISC_CTRL  = 16'h8020;
  localparam logic [15:0] ADDR_STATUS     = 16'h8024;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [29:0] RST_LIST_BASE = 30'h00000000;
  localparam logic [31:0] RST_SA_LOW    = 32'h00000000;
  localparam logic [15:0] RST_SA_HIGH   = 16'h0000;
  localparam logic [15:0] RST_MISC_CTRL = 16'hC180;

  // ---------------------------------------------------------------------------
  // Misc control field positions
  // ---------------------------------------------------------------------------
  localparam int MC_TXC_DELAY   = 15;
  localparam int MC_RXC_DELAY   = 14;
  localparam int MC_FACTORY     = 13;
  localparam int MC_PHY_ROLE    = 12;
  localparam int MC_RGMII       = 11;
  localparam int MC_JUMBO       = 10;
  localparam int MC_LEN_CHECK   = 9;
  localparam int MC_EXC_DEFER   = 8;
  localparam int MC_RX_EN       = 7;
  localparam int MC_SHORT_SLOT  = 6;
  localparam int MC_HD_FC2      = 5;
  localparam int MC_NO_EXC_COLL = 4;
  localparam int MC_COLL_LIMIT  = 3;
  localparam int MC_SPEED_LSB   = 1;
  localparam int MC_DUPLEX      = 0;

  // Status register field positions.
  localparam int ST_RX_STATE_LSB = 0;
  localparam int ST_RXC_PRESENT  = 8;
  localparam int ST_TX_STOPPED   = 9;

  // ---------------------------------------------------------------------------
  // Speeds, frame limits, backoff and timing
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  SPEED_10M         = 2'h0;
  localparam logic [1:0]  SPEED_100M        = 2'h1;
  localparam logic [1:0]  SPEED_1000M       = 2'h2;
  localparam logic [13:0] FRAME_LEN_JUMBO   = 14'h2400;
  localparam logic [13:0] FRAME_LEN_WAN     = 14'h07D0;
  localparam logic [13:0] FRAME_LEN_STD     = 14'h05EE;
  localparam logic [3:0]  BACKOFF_EXP_LIMIT = 4'h4;
  localparam logic [3:0]  BACKOFF_EXP_STD   = 4'hA;
  localparam int          RGMII_DELAY_PS    = 1500;
  localparam int          CLK_PERIOD_NS     = 4;
  localparam int          RXC_TIMEOUT_NS    = 256;
  localparam logic [7:0]  RXC_TIMEOUT_CYC   = 8'(RXC_TIMEOUT_NS / CLK_PERIOD_NS);

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    LMDC_RX_STOPPED   = 5'h01,
    LMDC_RX_CHECK     = 5'h02,
    LMDC_RX_RUNNING   = 5'h04,
    LMDC_RX_SUSPENDED = 5'h08,
    LMDC_RX_STOPPING  = 5'h10
  } lmdc_rx_state_t;

  typedef struct packed {
    logic [31:0] tx_list_start_address;
    logic [31:0] rx_list_start_address;
    logic [47:0] station_address;
    logic [1:0]  speed;
    logic        full_duplex;
    logic        rgmii_mode;
    logic        phy_role;
    logic        tx_clk_delay;
    logic        rx_clk_delay;
    logic [13:0] max_frame_len;
    logic        frame_len_check;
    logic        excess_defer;
    logic        mac_rx_enable;
    logic        short_slot;
    logic        hd_fc_mode2;
    logic        no_excess_coll;
    logic [3:0]  backoff_limit_exp;
  } lmdc_cfg_t;

  typedef struct packed {
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    logic [29:0]    tx_base;
    logic [29:0]    rx_base;
    logic [31:0]    sa_low;
    logic [15:0]    sa_high;
    logic [15:0]    misc;
    logic           trig;
    lmdc_rx_state_t rx_state;
    logic [2:0]     rxc_sync;
    logic           rxc_level;
    logic [7:0]     rxc_cnt;
    logic           rxc_present;
    lmdc_cfg_t      cfg;
  } lmdc_state_t;

endpackage : lmdc_pkg

// file: logic/lmdc_top.sv
// LAN MAC DMA control block: APB registers, receive restart sequencing and MAC line configuration.
`timescale 1ns/1ps

module lmdc_top
  import lmdc_pkg::*;
#(
  parameter bit IS_LAN_PORT = 1'b1
)
(
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                nrst_in,
  // APB slave
  input  wire logic [ADDR_W-1:0]   paddr_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // Receive DMA engine and transmit stop status
  input  wire logic                rx_dma_enable_in,
  input  wire logic                rx_desc_avail_in,
  input  wire logic                rx_desc_exhausted_in,
  input  wire logic                rx_frame_active_in,
  input  wire logic                tx_process_stopped_in,
  output logic                     rx_restart_trigger_out,
  output lmdc_rx_state_t           rx_state_out,
  // Line side
  input  wire logic                port_rx_clock_in,
  output logic                     rx_clock_present_out,
  output lmdc_cfg_t                cfg_out
);

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  lmdc_state_t state_r;
  lmdc_state_t state_nxt;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic        setup;
    logic        wr;
    logic        hit;
    logic [31:0] rdata;
    logic        rxc_edge;
    logic        rgmii_eff;
    logic [1:0]  speed_eff;
    setup     = psel_in & ~penable_in;
    wr        = psel_in & penable_in & state_r.pready & pwrite_in;
    hit       = 1'b1;
    rdata     = 32'h00000000;
    rxc_edge  = 1'b0;
    rgmii_eff = 1'b0;
    speed_eff = SPEED_10M;

    state_nxt         = state_r;
    state_nxt.pready  = 1'b0;
    state_nxt.pslverr = 1'b0;
    state_nxt.trig    = 1'b0;

    // Read decode; the restart command reads as zero.
    case (paddr_in)
      ADDR_RX_RESTART: rdata = 32'h00000000;
      ADDR_TX_BASE:    rdata = {state_r.tx_base, 2'b00};
      ADDR_RX_BASE:    rdata = {state_r.rx_base, 2'b00};
      ADDR_SA_LOW:     rdata = state_r.sa_low;
      ADDR_SA_HIGH:    rdata = {16'h0000, state_r.sa_high};
      ADDR_MISC_CTRL:  rdata = {16'h0000, state_r.misc};
      ADDR_STATUS:
      begin
        rdata[ST_RX_STATE_LSB +: 5] = state_r.rx_state;
        rdata[ST_RXC_PRESENT]       = state_r.rxc_present;
        rdata[ST_TX_STOPPED]        = tx_process_stopped_in;
      end
      default:         hit = 1'b0;
    endcase

    // The answer is prepared in the setup cycle and stands for one access cycle.
    if (setup)
    begin
      state_nxt.pready  = 1'b1;
      state_nxt.prdata  = pwrite_in ? 32'h00000000 : rdata;
      state_nxt.pslverr = ~hit;
    end

    // Writes take effect at the completing access edge only.
    if (wr)
    begin
      case (paddr_in)
        ADDR_RX_RESTART: state_nxt.trig = 1'b1;
        ADDR_TX_BASE:
        begin
          if (tx_process_stopped_in)
          begin
            state_nxt.tx_base = pwdata_in[31:2];
          end
        end
        ADDR_RX_BASE:
        begin
          if (state_r.rx_state == LMDC_RX_STOPPED)
          begin
            state_nxt.rx_base = pwdata_in[31:2];
          end
        end
        ADDR_SA_LOW:     state_nxt.sa_low  = pwdata_in;
        ADDR_SA_HIGH:    state_nxt.sa_high = pwdata_in[15:0];
        ADDR_MISC_CTRL:  state_nxt.misc    = pwdata_in[15:0];
        default:         state_nxt.trig    = 1'b0;
      endcase
    end

    // Receive process sequencing; the restart pulse is acted on one cycle after the write.
    case (state_r.rx_state)
      LMDC_RX_STOPPED:
      begin
        if (rx_dma_enable_in)
        begin
          state_nxt.rx_state = LMDC_RX_CHECK;
        end
      end
      LMDC_RX_CHECK:
      begin
        if (!rx_dma_enable_in)
        begin
          state_nxt.rx_state = LMDC_RX_STOPPED;
        end
        else if (rx_desc_avail_in)
        begin
          state_nxt.rx_state = LMDC_RX_RUNNING;
        end
        else
        begin
          state_nxt.rx_state = LMDC_RX_SUSPENDED;
        end
      end
      LMDC_RX_RUNNING:
      begin
        if (!rx_dma_enable_in)
        begin
          state_nxt.rx_state = rx_frame_active_in ? LMDC_RX_STOPPING : LMDC_RX_STOPPED;
        end
        else if (state_r.trig)
        begin
          state_nxt.rx_state = LMDC_RX_CHECK;
        end
        else if (rx_desc_exhausted_in)
        begin
          state_nxt.rx_state = LMDC_RX_SUSPENDED;
        end
      end
      LMDC_RX_SUSPENDED:
      begin
        if (!rx_dma_enable_in)
        begin
          state_nxt.rx_state = LMDC_RX_STOPPED;
        end
        else if (state_r.trig)
        begin
          state_nxt.rx_state = LMDC_RX_CHECK;
        end
      end
      LMDC_RX_STOPPING:
      begin
        if (!rx_frame_active_in)
        begin
          state_nxt.rx_state = LMDC_RX_STOPPED;
        end
      end
      default:
      begin
        state_nxt.rx_state = LMDC_RX_STOPPED;
      end
    endcase

    // Receive clock watch: three-stage synchroniser, level taken when stages two and three agree.
    state_nxt.rxc_sync = {state_r.rxc_sync[1:0], port_rx_clock_in};
    if (state_r.rxc_sync[1] == state_r.rxc_sync[2])
    begin
      state_nxt.rxc_level = state_r.rxc_sync[2];
      rxc_edge            = state_r.rxc_sync[2] & ~state_r.rxc_level;
    end
    if (rxc_edge)
    begin
      state_nxt.rxc_cnt     = 8'h00;
      state_nxt.rxc_present = 1'b1;
    end
    else if (state_r.rxc_cnt == RXC_TIMEOUT_CYC)
    begin
      state_nxt.rxc_present = 1'b0;
    end
    else
    begin
      state_nxt.rxc_cnt = state_r.rxc_cnt + 8'h01;
    end

    // Effective line configuration.
    rgmii_eff = state_r.misc[MC_RGMII] & ~IS_LAN_PORT;
    speed_eff = state_r.misc[MC_SPEED_LSB +: 2];
    if (speed_eff == 2'h3)
    begin
      speed_eff = SPEED_10M;
    end
    state_nxt.cfg.tx_list_start_address = {state_r.tx_base, 2'b00};
    state_nxt.cfg.rx_list_start_address = {state_r.rx_base, 2'b00};
    state_nxt.cfg.station_address       = {state_r.sa_high, state_r.sa_low};
    state_nxt.cfg.speed                 = speed_eff;
    state_nxt.cfg.full_duplex           = state_r.misc[MC_DUPLEX] | (speed_eff == SPEED_1000M);
    state_nxt.cfg.rgmii_mode            = rgmii_eff;
    state_nxt.cfg.phy_role              = state_r.misc[MC_PHY_ROLE];
    state_nxt.cfg.tx_clk_delay          = state_r.misc[MC_TXC_DELAY] & rgmii_eff;
    state_nxt.cfg.rx_clk_delay          = state_r.misc[MC_RXC_DELAY];
    if (IS_LAN_PORT)
    begin
      state_nxt.cfg.max_frame_len = state_r.misc[MC_JUMBO] ? FRAME_LEN_JUMBO : FRAME_LEN_STD;
    end
    else
    begin
      state_nxt.cfg.max_frame_len = FRAME_LEN_WAN;
    end
    state_nxt.cfg.frame_len_check       = state_r.misc[MC_LEN_CHECK];
    state_nxt.cfg.excess_defer          = state_r.misc[MC_EXC_DEFER];
    state_nxt.cfg.mac_rx_enable         = state_r.misc[MC_RX_EN];
    state_nxt.cfg.short_slot            = state_r.misc[MC_SHORT_SLOT];
    state_nxt.cfg.hd_fc_mode2           = state_r.misc[MC_HD_FC2];
    state_nxt.cfg.no_excess_coll        = state_r.misc[MC_NO_EXC_COLL];
    state_nxt.cfg.backoff_limit_exp     = state_r.misc[MC_COLL_LIMIT] ? BACKOFF_EXP_LIMIT : BACKOFF_EXP_STD;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r             <= '0;
      state_r.tx_base     <= RST_LIST_BASE;
      state_r.rx_base     <= RST_LIST_BASE;
      state_r.sa_low      <= RST_SA_LOW;
      state_r.sa_high     <= RST_SA_HIGH;
      state_r.misc        <= RST_MISC_CTRL;
      state_r.rx_state    <= LMDC_RX_STOPPED;
      state_r.cfg.excess_defer      <= 1'b1;
      state_r.cfg.mac_rx_enable     <= 1'b1;
      state_r.cfg.rx_clk_delay      <= 1'b1;
      state_r.cfg.full_duplex       <= 1'b0;
      state_r.cfg.max_frame_len     <= IS_LAN_PORT ? FRAME_LEN_STD : FRAME_LEN_WAN;
      state_r.cfg.backoff_limit_exp <= BACKOFF_EXP_STD;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata_out             = state_r.prdata;
  assign pready_out             = state_r.pready;
  assign pslverr_out            = state_r.pslverr;
  assign rx_restart_trigger_out = state_r.trig;
  assign rx_state_out           = state_r.rx_state;
  assign rx_clock_present_out   = state_r.rxc_present;
  assign cfg_out                = state_r.cfg;

endmodule : lmdc_top

// file: tb/lmdc_top_props.sv
// Assertions on APB timing, receive restart sequencing and line setup of the DMA control block.
`timescale 1ns/1ps

module lmdc_top_props
  import lmdc_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk_in,
  input wire logic              nrst_in,
  // APB
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  // Receive DMA and transmit stop status
  input wire logic              rx_dma_enable_in,
  input wire logic              rx_desc_avail_in,
  input wire logic              rx_desc_exhausted_in,
  input wire logic              rx_frame_active_in,
  input wire logic              tx_process_stopped_in,
  input wire logic              rx_restart_trigger_out,
  input wire lmdc_rx_state_t    rx_state_out,
  // Line side
  input wire logic              port_rx_clock_in,
  input wire logic              rx_clock_present_out,
  input wire lmdc_cfg_t         cfg_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic acc;
  logic rst_acc;
  assign acc     = psel_in && penable_in && pready_out;
  assign rst_acc = acc && paddr_in == ADDR_RX_RESTART;

  chk_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  chk_restart_fire: assert property (rst_acc && pwrite_in |=> rx_restart_trigger_out ##1 !rx_restart_trigger_out)
    else $error("restart write gave no single pulse");
  chk_restart_cause: assert property (rx_restart_trigger_out |-> $past(rst_acc && pwrite_in))
    else $error("trigger without restart write");
  chk_restart_read: assert property (rst_acc && !pwrite_in |-> prdata_out == 32'h00000000)
    else $error("restart read not zero");
  chk_restart_check: assert property (rx_restart_trigger_out && rx_dma_enable_in && !rx_desc_exhausted_in &&
    (rx_state_out == LMDC_RX_RUNNING || rx_state_out == LMDC_RX_SUSPENDED) |=> rx_state_out == LMDC_RX_CHECK)
    else $error("restart did not start a check");
  chk_check_run: assert property (rx_state_out == LMDC_RX_CHECK && rx_dma_enable_in && rx_desc_avail_in
    |=> rx_state_out == LMDC_RX_RUNNING)
    else $error("check with descriptors did not resume");
  chk_check_susp: assert property (rx_state_out == LMDC_RX_CHECK && rx_dma_enable_in && !rx_desc_avail_in
    |=> rx_state_out == LMDC_RX_SUSPENDED)
    else $error("check without descriptors did not suspend");
  chk_stop_done: assert property (rx_state_out == LMDC_RX_STOPPING && !rx_frame_active_in
    |=> rx_state_out == LMDC_RX_STOPPED)
    else $error("stop not taken after frame");
  chk_gig_full: assert property (cfg_out.speed == SPEED_1000M |-> cfg_out.full_duplex)
    else $error("gigabit without full duplex");
  chk_misc_upper: assert property (acc && !pwrite_in && paddr_in == ADDR_MISC_CTRL |-> prdata_out[31:16] == 16'h0000)
    else $error("reserved control bits not zero");
endmodule : lmdc_top_props

bind lmdc_top lmdc_top_props u_props (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .paddr_in(paddr_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .rx_dma_enable_in(rx_dma_enable_in),
  .rx_desc_avail_in(rx_desc_avail_in), .rx_desc_exhausted_in(rx_desc_exhausted_in),
  .rx_frame_active_in(rx_frame_active_in), .tx_process_stopped_in(tx_process_stopped_in),
  .rx_restart_trigger_out(rx_restart_trigger_out), .rx_state_out(rx_state_out),
  .port_rx_clock_in(port_rx_clock_in), .rx_clock_present_out(rx_clock_present_out), .cfg_out(cfg_out));

// file: tb/lmdc_phy_model.sv
// Line partner: receive clock of 32 ns that runs only while a frame is on the wire.
`timescale 1ns/1ps

module lmdc_phy_model
(
  // Frame request from the bench
  input  wire logic frame_in,
  // Receive line clock
  output logic      port_rx_clock_out
);
  initial
  begin
    port_rx_clock_out = 1'b0;
    forever
    begin
      #3;
      wait (frame_in);
      while (frame_in)
      begin
        #16 port_rx_clock_out = 1'b1;
        #16 port_rx_clock_out = 1'b0;
      end
    end
  end
endmodule : lmdc_phy_model

// file: tb/tb.sv
// Self-checking bench for the DMA control block: registers, restart sequencing and line setup.
`timescale 1ns/1ps

module tb;
  import lmdc_pkg::*;
  logic           clk = 1'b0;
  logic           nrst = 1'b0;
  logic [15:0]    paddr = 16'h0000;
  logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]    pwdata = 32'h00000000, prdata, rd;
  logic           pready, pslverr, trig, present, rxclk, er;
  logic           en = 1'b0, avail = 1'b0, exh = 1'b0, frame = 1'b0, txstop = 1'b1;
  lmdc_rx_state_t st;
  lmdc_cfg_t      cfg;
  int             n_fail = 0, cmp_count = 0, cyc = 0;

  always #2 clk = ~clk;

  lmdc_top DUT (.core_clk_in(clk), .nrst_in(nrst), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .rx_dma_enable_in(en), .rx_desc_avail_in(avail), .rx_desc_exhausted_in(exh), .rx_frame_active_in(frame),
    .tx_process_stopped_in(txstop), .rx_restart_trigger_out(trig), .rx_state_out(st),
    .port_rx_clock_in(rxclk), .rx_clock_present_out(present), .cfg_out(cfg));
  lmdc_phy_model u_phy (.frame_in(frame), .port_rx_clock_out(rxclk));

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk({er, rd}, {1'b0, exp});
  endtask : rdc

  task automatic wst(input lmdc_rx_state_t exp);
    for (int i = 0; i < 10 && st !== exp; i++)
      @(posedge clk);
    chk(st, exp);
  endtask : wst

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(ADDR_MISC_CTRL, 32'h0000C180);
    rdc(ADDR_TX_BASE, 32'h00000000);
    rdc(ADDR_SA_HIGH, 32'h00000000);
    rdc(ADDR_RX_RESTART, 32'h00000000);
    chk(trig, 1'b0);
    $display("test reset done");
    apb(1'b1, ADDR_SA_LOW, 32'h11223344);
    apb(1'b1, ADDR_SA_HIGH, 32'hFFFF5566);
    rdc(ADDR_SA_LOW, 32'h11223344);
    rdc(ADDR_SA_HIGH, 32'h00005566);
    chk(cfg.station_address, 48'h556611223344);
    apb(1'b1, ADDR_TX_BASE, 32'h12345678);
    txstop <= 1'b0;
    apb(1'b1, ADDR_TX_BASE, 32'hAAAAAAA8);
    rdc(ADDR_TX_BASE, 32'h12345678);
    chk(cfg.tx_list_start_address, 32'h12345678);
    apb(1'b1, ADDR_RX_BASE, 32'h0000F00C);
    rdc(ADDR_RX_BASE, 32'h0000F00C);
    apb(1'b0, 16'h8028, 32'h00000000);
    chk(er, 1'b1);
    $display("test registers done");
    en <= 1'b1;
    wst(LMDC_RX_SUSPENDED);
    apb(1'b1, ADDR_RX_RESTART, 32'h00000000);
    chk(trig, 1'b1);
    @(posedge clk);
    chk(st, LMDC_RX_CHECK);
    @(posedge clk);
    chk(st, LMDC_RX_SUSPENDED);
    avail <= 1'b1;
    apb(1'b1, ADDR_RX_RESTART, 32'hFFFFFFFF);
    wst(LMDC_RX_RUNNING);
    rdc(ADDR_RX_RESTART, 32'h00000000);
    apb(1'b1, ADDR_RX_BASE, 32'h00000040);
    rdc(ADDR_RX_BASE, 32'h0000F00C);
    exh <= 1'b1;
    avail <= 1'b0;
    @(posedge clk);
    exh <= 1'b0;
    wst(LMDC_RX_SUSPENDED);
    avail <= 1'b1;
    apb(1'b1, ADDR_RX_RESTART, 32'h00000000);
    wst(LMDC_RX_RUNNING);
    $display("test restart done");
    frame <= 1'b1;
    repeat (16) @(posedge clk);
    chk(present, 1'b1);
    en <= 1'b0;
    wst(LMDC_RX_STOPPING);
    repeat (4) @(posedge clk);
    chk(st, LMDC_RX_STOPPING);
    frame <= 1'b0;
    wst(LMDC_RX_STOPPED);
    repeat (80) @(posedge clk);
    chk(present, 1'b0);
    $display("test stop done");
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, ADDR_MISC_CTRL, 32'hFFFFC588 | (32'(s) << 1));
      rdc(ADDR_MISC_CTRL, 32'h0000C588 | (32'(s) << 1));
      chk({cfg.speed, cfg.full_duplex}, {(s == 3) ? 2'h0 : 2'(s), s == 2});
    end
    chk({cfg.backoff_limit_exp, cfg.max_frame_len}, {BACKOFF_EXP_LIMIT, FRAME_LEN_JUMBO});
    chk({cfg.tx_clk_delay, cfg.rx_clk_delay, cfg.mac_rx_enable}, 3'h3);
    apb(1'b1, ADDR_MISC_CTRL, 32'h00001801);
    @(posedge clk);
    chk({cfg.phy_role, cfg.rgmii_mode, cfg.rx_clk_delay, cfg.full_duplex, cfg.excess_defer}, 5'h12);
    chk({cfg.backoff_limit_exp, cfg.max_frame_len}, {BACKOFF_EXP_STD, FRAME_LEN_STD});
    apb(1'b1, ADDR_MISC_CTRL, 32'h00000270);
    @(posedge clk);
    chk({cfg.frame_len_check, cfg.excess_defer, cfg.short_slot, cfg.hd_fc_mode2, cfg.no_excess_coll}, 5'h17);
    chk(cfg.rx_list_start_address, 32'h0000F00C);
    rdc(ADDR_STATUS, 32'h00000001);
    $display("test control done");
    test_done();
  end
endmodule : tb
